// ===== src/acc_pkg.sv
package acc_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL0_OFFS = 8'h00;
  localparam logic [7:0] CTRL2_OFFS = 8'h04;
  localparam logic [7:0] RES_HI_OFFS = 8'h08;
  localparam logic [7:0] RES_LO_OFFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFFS = 8'h14;
  localparam logic [7:0] INSTR_OFFS = 8'h18;
  // ****************************************
  // fields
  // ****************************************
  localparam int EN_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHS_LSB = 2;
  localparam int CHS_W = 4;
  localparam int ACQ_W = 3;
  localparam int RES_W = 10;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [2:0] CTRL2_RST = 3'h0;
  // ****************************************
  // timing: one bit period in core clocks
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int TAD_NS = 1000;
  localparam int TAD_CYC = (TAD_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b000,
    ACC_DEFER = 3'b001,
    ACC_ACQ = 3'b010,
    ACC_CONV = 3'b011,
    ACC_LOAD = 3'b100
  } acc_state_t;
  // acquisition periods per code
  function automatic logic [4:0] acc_acq_periods(input logic [2:0] code);
    case (code)
      3'h0: acc_acq_periods = 5'h00;
      3'h1: acc_acq_periods = 5'h02;
      3'h2: acc_acq_periods = 5'h04;
      3'h3: acc_acq_periods = 5'h06;
      3'h4: acc_acq_periods = 5'h08;
      3'h5: acc_acq_periods = 5'h0C;
      3'h6: acc_acq_periods = 5'h10;
      default: acc_acq_periods = 5'h14;
    endcase
  endfunction
endpackage

// ===== src/acc_sar.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// successive approximation trial register
// ****************************************
module acc_sar
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic [3:0] bit_idx_i,
  input wire logic cmp_i,
  output logic [9:0] trial_o
);
  import acc_pkg::*;
  logic [9:0] trial_r;
  logic [9:0] trial_nxt;
  // trial bit set, then kept or dropped by the comparator, msb first
  always_comb
  begin
    trial_nxt = trial_r;
    if (clear_i)
      trial_nxt = 10'h200;
    else if (step_i)
    begin
      trial_nxt[bit_idx_i] = cmp_i;
      if (bit_idx_i != 4'h0)
        trial_nxt[bit_idx_i - 4'h1] = 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      trial_r <= 10'h000;
    else
      trial_r <= trial_nxt;
  end
  assign trial_o = trial_r;
endmodule // acc_sar
`default_nettype wire

// ===== src/acc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// converter control with apb registers
// ****************************************
module acc_ctrl
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_i,
  output logic conv_power_o,
  output logic [3:0] channel_o,
  output logic sample_o,
  output logic [9:0] dac_trial_o,
  output logic irq_o
);
  import acc_pkg::*;
  typedef struct packed {
    logic en;
    logic go;
    logic [3:0] input_channel_select;
    logic [2:0] acq;
    logic [9:0] res;
    logic done_st;
    logic done_msk;
    acc_state_t st;
    logic [5:0] tad_cnt;
    logic [4:0] per_cnt;
    logic [3:0] bit_idx;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic sample;
    logic irq;
  } acc_regs_t;
  acc_regs_t q_r;
  acc_regs_t q_nxt;
  logic [9:0] trial;
  logic wr_acc;
  logic rd_acc;
  logic tad_tick;
  logic sar_clear;
  logic sar_step;
  // ****************************************
  // bus decode
  // ****************************************
  // single answer after one wait state: pready in the second access-phase cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign tad_tick = (q_r.tad_cnt == 6'(TAD_CYC - 1));
  assign sar_clear = (q_r.st == ACC_ACQ || q_r.st == ACC_DEFER) && q_nxt.st == ACC_CONV;
  assign sar_step = (q_r.st == ACC_CONV) && tad_tick;
  acc_sar u_sar
  (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(sar_clear),
    .step_i(sar_step),
    .bit_idx_i(q_r.bit_idx),
    .cmp_i(cmp_i),
    .trial_o(trial)
  );
  function automatic logic [31:0] rd_mux(input acc_regs_t s, input logic [7:0] a);
    case (a)
      CTRL0_OFFS: rd_mux = {26'h0, s.input_channel_select, s.go, s.en};
      CTRL2_OFFS: rd_mux = {29'h0, s.acq};
      RES_HI_OFFS: rd_mux = {30'h0, s.res[9:8]};
      RES_LO_OFFS: rd_mux = {24'h0, s.res[7:0]};
      IRQ_STAT_OFFS: rd_mux = {31'h0, s.done_st};
      IRQ_MASK_OFFS: rd_mux = {31'h0, s.done_msk};
      default: rd_mux = 32'h0;
    endcase
  endfunction
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rdy = 1'b0;
    q_nxt.err = 1'b0;
    q_nxt.tad_cnt = (q_r.st == ACC_IDLE || q_r.st == ACC_DEFER || tad_tick)
      ? 6'h00 : q_r.tad_cnt + 6'h01;
    // register access, answered one cycle into the access phase
    if ((wr_acc || rd_acc) && !q_r.rdy)
    begin
      q_nxt.rdy = 1'b1;
      q_nxt.err = (paddr > INSTR_OFFS) || (paddr[1:0] != 2'b00);
      q_nxt.rdata = rd_mux(q_r, paddr);
      if (rd_acc && paddr == IRQ_STAT_OFFS)
        q_nxt.done_st = 1'b0; // read clears
      if (wr_acc)
      begin
        case (paddr)
          CTRL0_OFFS:
          begin
            q_nxt.en = pwdata[EN_BIT];
            q_nxt.input_channel_select = pwdata[CHS_LSB +: CHS_W];
            // start only taken with the converter already on
            if (pwdata[GO_BIT] && q_r.en && pwdata[EN_BIT] && q_r.st == ACC_IDLE)
            begin
              q_nxt.go = 1'b1;
              q_nxt.st = ACC_DEFER;
            end
          end
          CTRL2_OFFS: q_nxt.acq = pwdata[ACQ_W-1:0];
          IRQ_MASK_OFFS: q_nxt.done_msk = pwdata[0];
          default: q_nxt.en = q_nxt.en;
        endcase
      end
    end
    // ****************************************
    // conversion sequencer
    // ****************************************
    case (q_r.st)
      ACC_IDLE: q_nxt.sample = q_nxt.en;
      ACC_DEFER:
      begin
        // waits for the next instruction strobe write
        if (wr_acc && !q_r.rdy && paddr == INSTR_OFFS)
        begin
          q_nxt.per_cnt = acc_acq_periods(q_r.acq);
          q_nxt.bit_idx = 4'(RES_W - 1);
          if (q_r.acq == 3'h0)
          begin
            q_nxt.st = ACC_CONV;
            q_nxt.sample = 1'b0;
          end
          else
            q_nxt.st = ACC_ACQ;
        end
      end
      ACC_ACQ:
        if (tad_tick)
        begin
          q_nxt.per_cnt = q_r.per_cnt - 5'h01;
          if (q_r.per_cnt == 5'h01)
          begin
            q_nxt.st = ACC_CONV;
            q_nxt.sample = 1'b0;
          end
        end
      ACC_CONV:
        if (tad_tick)
        begin
          q_nxt.bit_idx = q_r.bit_idx - 4'h1;
          if (q_r.bit_idx == 4'h0)
            q_nxt.st = ACC_LOAD;
        end
      ACC_LOAD:
      begin
        q_nxt.res = trial;
        q_nxt.go = 1'b0;
        q_nxt.done_st = 1'b1; // set beats read clear
        q_nxt.st = ACC_IDLE;
      end
      default: q_nxt.st = ACC_IDLE;
    endcase
    // disabling aborts everything
    if (!q_nxt.en)
    begin
      q_nxt.st = ACC_IDLE;
      q_nxt.go = 1'b0;
      q_nxt.sample = 1'b0;
    end
    q_nxt.irq = q_nxt.done_st && q_nxt.done_msk;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q_r <= '0;
      q_r.st <= ACC_IDLE;
    end
    else
      q_r <= q_nxt;
  end
  assign prdata = q_r.rdata;
  assign pready = q_r.rdy;
  assign pslverr = q_r.err;
  assign conv_power_o = q_r.en;
  assign channel_o = q_r.input_channel_select;
  assign sample_o = q_r.sample;
  assign dac_trial_o = trial;
  assign irq_o = q_r.irq;
  // ****************************************
  // checks
  // ****************************************
  sequence s_last_step;
    q_r.st == ACC_CONV && tad_tick && q_r.bit_idx == 4'h0;
  endsequence
  a_done_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_last_step |=> ##1 (!q_r.go && q_r.res == $past(trial)))
    else $error("result and flag not updated together");
  a_off_no_go: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !q_r.en |-> q_r.st == ACC_IDLE && !q_r.go)
    else $error("sequence running while disabled");
  a_go_busy: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    q_r.st != ACC_IDLE |-> q_r.go)
    else $error("flag low during conversion");
  a_defer_wait: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(q_r.go) |-> q_r.st == ACC_DEFER)
    else $error("conversion started without defer");
  a_acq_four: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (q_r.st == ACC_DEFER && q_nxt.st == ACC_ACQ && q_r.acq == 3'h2) |=>
      q_r.per_cnt == 5'h04)
    else $error("acquisition length wrong");
  a_acq_none: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (q_r.st == ACC_DEFER && q_r.acq == 3'h0) |=> q_r.st != ACC_ACQ)
    else $error("acquisition run with code zero");
  a_ten_bits: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(q_r.st == ACC_CONV) |-> q_r.bit_idx == 4'h9)
    else $error("conversion not starting at msb");
  // ****************************************
  // bus, routing and sequencing checks
  // ****************************************
  // named steps shared by the properties below
  sequence s_ctrl0_write;
    wr_acc && !q_r.rdy && paddr == CTRL0_OFFS;
  endsequence
  sequence s_instr_zero;
    q_r.st == ACC_DEFER && q_r.acq == 3'h0 && wr_acc && !q_r.rdy && paddr == INSTR_OFFS;
  endsequence
  sequence s_acq_four_start;
    q_r.st == ACC_DEFER && q_nxt.st == ACC_ACQ && q_r.acq == 3'h2;
  endsequence
  sequence s_conv_entry;
    $rose(q_r.st == ACC_CONV);
  endsequence
  sequence s_load;
    q_r.st == ACC_LOAD;
  endsequence

  // power follows the enable bit of the last control write
  a_power_en: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_ctrl0_write |=> conv_power_o == $past(pwdata[EN_BIT]))
    else $error("power does not follow enable");

  // the bus answer is a single-cycle pulse
  a_ready_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  // an error response never comes without ready
  a_err_ready: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    pslverr |-> pready)
    else $error("error flag without ready");

  // addresses past the map answer with an error and zero data
  a_bad_addr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (psel && penable && !q_r.rdy && paddr > INSTR_OFFS) |=> pslverr && prdata == 32'h0)
    else $error("out of range access not refused");

  // the two unimplemented bits and everything above read zero
  a_top_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (pready && $past(paddr) == CTRL0_OFFS) |-> prdata[31:6] == 26'h0)
    else $error("unimplemented control bits not zero");

  // the channel pins follow the written selector
  a_chan_route: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_ctrl0_write |=> channel_o == $past(pwdata[CHS_LSB +: CHS_W]))
    else $error("channel select not routed");

  // a start written while the converter is off is dropped
  a_go_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (wr_acc && !q_r.rdy && paddr == CTRL0_OFFS && !q_r.en) |=> !q_r.go)
    else $error("start taken while disabled");

  // a start taken on a powered, idle converter waits in defer
  a_go_taken: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (wr_acc && !q_r.rdy && paddr == CTRL0_OFFS && q_r.en && pwdata[EN_BIT]
      && pwdata[GO_BIT] && q_r.st == ACC_IDLE) |=> q_r.go && q_r.st == ACC_DEFER)
    else $error("start not taken");

  // no instruction strobe, no start: software may still enter sleep
  a_no_early: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (q_r.st == ACC_DEFER && q_nxt.en
      && !(wr_acc && !q_r.rdy && paddr == INSTR_OFFS)) |=> q_r.st == ACC_DEFER)
    else $error("conversion left defer without instruction");

  // code zero goes straight to the first bit with the cap disconnected
  a_zero_direct: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_instr_zero |=> q_r.st == ACC_CONV && !sample_o)
    else $error("code zero did not start at once");

  // code two tracks for exactly four bit periods of fifty clocks
  a_acq_span: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_acq_four_start |-> ##200 (q_r.st == ACC_ACQ || !q_r.en)
      ##1 (q_r.st == ACC_CONV || !q_r.en))
    else $error("acquisition not four bit periods");

  // the first decision falls one full bit period after entry
  a_step_period: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_conv_entry |-> ##49 (sar_step || !q_r.en))
    else $error("bit period length wrong");

  // the trial word restarts at the msb half scale
  a_sar_seed: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    sar_clear |=> dac_trial_o == 10'h200)
    else $error("trial word not seeded");

  // the msb decision keeps the comparator verdict and arms the next bit
  a_msb_first: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (sar_step && q_r.bit_idx == 4'h9) |=> dac_trial_o[9] == $past(cmp_i) && dac_trial_o[8])
    else $error("msb decision wrong");

  // the load cycle only follows the lsb decision
  a_last_bit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_load |-> $past(q_r.st) == ACC_CONV && $past(q_r.bit_idx) == 4'h0)
    else $error("load without ten decisions");

  // flag clear, status set and idle all land on one edge
  a_flag_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_load |=> !q_r.go && q_r.done_st && q_r.st == ACC_IDLE)
    else $error("flag and status not updated together");

  // results only change in the load cycle
  a_res_stable: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    q_r.st != ACC_LOAD |=> $stable(q_r.res))
    else $error("result changed outside load");

  // an unmasked completion raises the interrupt on the next edge
  a_irq_raise: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_load |=> irq_o || !q_r.done_msk)
    else $error("interrupt not raised");

  // reading status clears it unless a completion lands at once
  a_read_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (rd_acc && !q_r.rdy && paddr == IRQ_STAT_OFFS && q_r.st != ACC_LOAD)
      |=> !q_r.done_st && !irq_o)
    else $error("status read did not clear");

  // the holding cap is disconnected while bits are resolved
  a_conv_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    q_r.st == ACC_CONV |-> !sample_o)
    else $error("input still sampled during conversion");

  // the cap keeps tracking through the acquisition interval
  a_acq_track: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    q_r.st == ACC_ACQ |-> sample_o)
    else $error("input not tracked during acquisition");

  // a powered idle converter tracks its input
  a_idle_track: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (q_r.st == ACC_IDLE && q_nxt.en) |=> sample_o)
    else $error("idle converter not tracking");

  // the trial word is frozen while idle
  a_trial_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    q_r.st == ACC_IDLE |=> $stable(dac_trial_o))
    else $error("trial word moved while idle");
endmodule // acc_ctrl
`default_nettype wire

// ===== bench/acc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// comparator stand-in
// ****************************************
module acc_far_model
(
  input wire logic core_clk_i,
  input wire logic power_i,
  input wire logic [9:0] trial_i,
  input wire logic [9:0] level_i,
  output logic cmp_o
);
  logic junk_r = 1'b0;
  // unpowered output wanders, so a design that trusts it is caught
  always_ff @(posedge core_clk_i)
  begin
    junk_r <= ~junk_r;
  end
  assign cmp_o = power_i ? (level_i >= trial_i) : junk_r;
endmodule // acc_far_model
`default_nettype wire

// ===== bench/adc_conversion_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control_tb_top;
  import acc_pkg::*;
  typedef struct packed {logic [31:0] val; logic [31:0] mask;} acc_note_t;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmp, power, sample, irq;
  logic [3:0] chan;
  logic [9:0] trial;
  logic [9:0] level_r = 10'h000;
  logic [15:0] lfsr_r = 16'h9DF1;
  acc_note_t notes[$];
  acc_note_t cur;
  logic last_err = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int cyc[2];
  always #10 core_clk_i = ~core_clk_i;
  acc_ctrl acc_ctrl_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_i(cmp), .conv_power_o(power),
    .channel_o(chan), .sample_o(sample), .dac_trial_o(trial), .irq_o(irq));
  acc_far_model acc_far_model_inst (.core_clk_i(core_clk_i), .power_i(power),
    .trial_i(trial), .level_i(level_r), .cmp_o(cmp));
  // ****************************************
  // checking
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // read results are judged here against the oldest note
  always @(posedge core_clk_i)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      cur = notes.pop_front();
      chk(prdata & cur.mask, cur.val & cur.mask, "read data");
    end
  end
  // sixteen-bit feedback register feeding random data to the block
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // one apb transfer; on reads d is the expected value
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    int n;
    @(posedge core_clk_i);
    lfsr_r = lfsr_next(lfsr_r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : {16'h0, lfsr_r};
    if (!w)
      notes.push_back({d, m});
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (!pready && n < 20);
    last_err = pslverr;
    if (!pready)
    begin
      failures++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one full conversion against a random input level
  task automatic conv(input logic [2:0] acq, output int c);
    logic [9:0] tgt;
    tgt = lfsr_r[9:0];
    level_r <= tgt;
    apb(1, CTRL2_OFFS, {29'h0, acq}, 0);
    apb(1, CTRL0_OFFS, 32'h3F, 0);
    apb(0, CTRL0_OFFS, 32'h02, 32'h02);
    repeat (600) @(posedge core_clk_i);
    apb(0, IRQ_STAT_OFFS, 32'h0, 32'h1);
    apb(1, INSTR_OFFS, 32'h0, 0);
    chk({31'h0, sample}, {31'h0, acq != 3'h0}, "sample phase");
    c = 0;
    while (!irq && c < 2000)
    begin
      @(posedge core_clk_i);
      c++;
    end
    if (!irq)
    begin
      failures++;
      stop_test();
    end
    apb(0, CTRL0_OFFS, 32'h3D, 32'hFF);
    apb(0, RES_HI_OFFS, {30'h0, tgt[9:8]}, 32'h3);
    apb(0, RES_LO_OFFS, {24'h0, tgt[7:0]}, 32'hFF);
    apb(1, IRQ_MASK_OFFS, 32'h0, 0);
    repeat (2) @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1, IRQ_MASK_OFFS, 32'h1, 0);
    repeat (2) @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h1, "irq");
    apb(0, IRQ_STAT_OFFS, 32'h1, 32'h1);
    apb(0, IRQ_STAT_OFFS, 32'h0, 32'h1);
    repeat (2) @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    apb(0, CTRL0_OFFS, 32'h0, 32'hFF);
    chk({31'h0, last_err}, 32'h0, "no slave error");
    apb(1, CTRL0_OFFS, 32'h02, 0);
    apb(0, CTRL0_OFFS, 32'h0, 32'hFF);
    chk({31'h0, power}, 32'h0, "power off");
    // reserved codes 12 and 13 are never selected
    for (int ch = 0; ch < 16; ch++)
    begin
      if (ch == 12 || ch == 13)
        continue;
      apb(1, CTRL0_OFFS, 32'hC1 | (ch << 2), 0);
      chk({28'h0, chan}, ch, "channel");
      apb(0, CTRL0_OFFS, 32'h01 | (ch << 2), 32'hFF);
    end
    chk({31'h0, power}, 32'h1, "power on");
    chk({31'h0, sample}, 32'h1, "sample tracks");
    apb(0, 8'h1C, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, last_err}, 32'h1, "slave error");
    apb(1, IRQ_MASK_OFFS, 32'h1, 0);
    conv(3'h0, cyc[0]);
    conv(3'h2, cyc[1]);
    chk(cyc[1] - cyc[0], 4 * TAD_CYC, "acquisition delay");
    stop_test();
  end
endmodule // adc_conversion_control_tb_top
`default_nettype wire
